/* File: verilog/sideband_pkg.sv */
// constants shared by the sideband retiming stage
package sideband_pkg;
   // ------------------------------------------------------------
   // signal widths
   // ------------------------------------------------------------
   localparam int BUSDEV_WIDTH = 13;     // bus and device number
   localparam int DEVCSR_WIDTH = 32;     // device control and status
   localparam int LINKCSR_WIDTH = 32;    // link control and status
   localparam int TCVCMAP_WIDTH = 24;    // traffic class to channel map
   localparam int CPLERR_WIDTH = 3;      // completion error flags
   localparam int MSINUM_WIDTH = 5;      // interrupt message number
   localparam int TEST_WIDTH = 512;      // core test vector
   localparam int DEBUG_WIDTH = 9;       // debug output
   // ------------------------------------------------------------
   // debug field positions in the test vector
   // ------------------------------------------------------------
   localparam int LTS_WIDE_LSB = 0;      // training state, eight lanes
   localparam int LTS_NARROW_LSB = 320;  // training state, four or one lane
   localparam int LTS_WIDTH = 5;         // training state width
   localparam int LANE_WIDE_LSB = 88;    // active lanes, eight lanes
   localparam int LANE_NARROW_LSB = 408; // active lanes, four or one lane
   localparam int LANE_WIDTH = 4;        // active lane field width
   // ------------------------------------------------------------
   // debug field positions in the output
   // ------------------------------------------------------------
   localparam int DBG_LTS_LSB = 0;       // training state at bits 4:0
   localparam int DBG_LANE_LSB = 5;      // active lanes at bits 8:5
   localparam int DELAY_CYCLES = 1;      // retiming depth
   localparam int WIDE_LANES = 8;        // lane count that uses low fields
endpackage

/* File: verilog/debug_select.sv */
// lane-width dependent selection of the debug fields
`timescale 1ns/1ps
module debug_select #(
   parameter int LANES = 8                     // fixed at build time
) (
   input wire logic [sideband_pkg::TEST_WIDTH-1:0] test_vector,  // core test vector
   output logic [sideband_pkg::DEBUG_WIDTH-1:0] debug_word       // selected debug bits
);
   // ------------------------------------------------------------
   // static field pick
   // ------------------------------------------------------------
   localparam int LTS_LSB = (LANES == sideband_pkg::WIDE_LANES) ?
      sideband_pkg::LTS_WIDE_LSB : sideband_pkg::LTS_NARROW_LSB;   // RQ13
   localparam int LANE_LSB = (LANES == sideband_pkg::WIDE_LANES) ?
      sideband_pkg::LANE_WIDE_LSB : sideband_pkg::LANE_NARROW_LSB; // RQ13

   // assemble the nine-bit word from the two fields
   always_comb begin
      debug_word = {test_vector[LANE_LSB +: sideband_pkg::LANE_WIDTH],   // RQ11
                    test_vector[LTS_LSB +: sideband_pkg::LTS_WIDTH]};    // RQ10
   end
endmodule

/* File: verilog/sideband_retiming_stage.sv */
// one-clock retiming of sideband signals from core to application
`timescale 1ns/1ps
// How it works
// RQ1 - interrupt status copied, one clock late
// RQ2 - bus and device number delayed copy
// RQ3 - device control status delayed copy
// RQ4 - link control status registered one clock
// RQ5 - channel map delayed copy
// RQ6 - completion error delayed one clock
// RQ7 - interrupt message number delayed one clock
// RQ8 - completion pending delayed one clock
// RQ9 - nine-bit debug subset of test vector
// RQ10 - training state in bits 4:0
// RQ11 - active lanes from lane-dependent test bits
// RQ12 - active lanes at 8:5, one-clock delays
// RQ13 - lane width fixed by static parameter
module sideband_retiming_stage #(
   parameter int LANES = 8                               // core lane count: 8, 4 or 1
) (
   input wire logic sys_clk,                             // system clock
   input wire logic rst,                                 // synchronous reset, high
   input wire logic clk_en,                              // freezes state when low, unless reset is high
   input wire logic int_sts_core,                        // core interrupt status
   input wire logic [sideband_pkg::BUSDEV_WIDTH-1:0] busdev_core,   // bus/device number
   input wire logic [sideband_pkg::DEVCSR_WIDTH-1:0] devcsr_core,   // device csr
   input wire logic [sideband_pkg::LINKCSR_WIDTH-1:0] linkcsr_core, // link csr
   input wire logic [sideband_pkg::TCVCMAP_WIDTH-1:0] tcvcmap_core, // tc/vc map
   input wire logic [sideband_pkg::CPLERR_WIDTH-1:0] cpl_err_core,  // completion error
   input wire logic [sideband_pkg::MSINUM_WIDTH-1:0] msi_num_core,  // msi number
   input wire logic cpl_pending_core,                    // completion pending
   input wire logic [sideband_pkg::TEST_WIDTH-1:0] test_core,       // test vector
   output logic int_sts_app,                             // delayed interrupt status
   output logic [sideband_pkg::BUSDEV_WIDTH-1:0] busdev_app,        // delayed bus/device
   output logic [sideband_pkg::DEVCSR_WIDTH-1:0] devcsr_app,        // delayed device csr
   output logic [sideband_pkg::LINKCSR_WIDTH-1:0] linkcsr_app,      // delayed link csr
   output logic [sideband_pkg::TCVCMAP_WIDTH-1:0] tcvcmap_app,      // delayed tc/vc map
   output logic [sideband_pkg::CPLERR_WIDTH-1:0] cpl_err_app,       // delayed completion error
   output logic [sideband_pkg::MSINUM_WIDTH-1:0] msi_num_app,       // delayed msi number
   output logic cpl_pending_app,                         // delayed completion pending
   output logic [sideband_pkg::DEBUG_WIDTH-1:0] debug_app           // delayed debug word
);
   // ------------------------------------------------------------
   // debug field selection
   // ------------------------------------------------------------
   logic [sideband_pkg::DEBUG_WIDTH-1:0] debug_pick;     // combinational debug word

   debug_select #(
      .LANES(LANES)
   ) u_debug_select (
      .test_vector(test_core),
      .debug_word(debug_pick)
   );

   // ------------------------------------------------------------
   // next-value logic
   // ------------------------------------------------------------
   logic next_int_sts;                                   // next interrupt status
   logic [sideband_pkg::BUSDEV_WIDTH-1:0] next_busdev;   // next bus/device
   logic [sideband_pkg::DEVCSR_WIDTH-1:0] next_devcsr;   // next device csr
   logic [sideband_pkg::LINKCSR_WIDTH-1:0] next_linkcsr; // next link csr
   logic [sideband_pkg::TCVCMAP_WIDTH-1:0] next_tcvcmap; // next tc/vc map
   logic [sideband_pkg::CPLERR_WIDTH-1:0] next_cpl_err;  // next completion error
   logic [sideband_pkg::MSINUM_WIDTH-1:0] next_msi_num;  // next msi number
   logic next_cpl_pending;                               // next completion pending
   logic [sideband_pkg::DEBUG_WIDTH-1:0] next_debug;     // next debug word

   // hold while disabled, clear under reset, otherwise sample the core
   always_comb begin
      next_int_sts = int_sts_app;
      next_busdev = busdev_app;
      next_devcsr = devcsr_app;
      next_linkcsr = linkcsr_app;
      next_tcvcmap = tcvcmap_app;
      next_cpl_err = cpl_err_app;
      next_msi_num = msi_num_app;
      next_cpl_pending = cpl_pending_app;
      next_debug = debug_app;
      if (rst) begin
         next_int_sts = 1'b0;
         next_busdev = '0;
         next_devcsr = '0;
         next_linkcsr = '0;
         next_tcvcmap = '0;
         next_cpl_err = '0;
         next_msi_num = '0;
         next_cpl_pending = 1'b0;
         next_debug = '0;
      end else if (clk_en) begin
         next_int_sts = int_sts_core;            // RQ1
         next_busdev = busdev_core;              // RQ2
         next_devcsr = devcsr_core;              // RQ3
         next_linkcsr = linkcsr_core;            // RQ4
         next_tcvcmap = tcvcmap_core;            // RQ5
         next_cpl_err = cpl_err_core;            // RQ6
         next_msi_num = msi_num_core;            // RQ7
         next_cpl_pending = cpl_pending_core;    // RQ8
         next_debug = debug_pick;                // RQ9
      end
   end

   // ------------------------------------------------------------
   // output registers
   // ------------------------------------------------------------
   // one stage of flops for every sideband output
   always_ff @(posedge sys_clk) begin
      int_sts_app <= next_int_sts;
      busdev_app <= next_busdev;
      devcsr_app <= next_devcsr;
      linkcsr_app <= next_linkcsr;
      tcvcmap_app <= next_tcvcmap;
      cpl_err_app <= next_cpl_err;
      msi_num_app <= next_msi_num;
      cpl_pending_app <= next_cpl_pending;
      debug_app <= next_debug;                   // RQ12
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // ------------------------------------------------------------
   // field bases for the checks
   // ------------------------------------------------------------
   // test-vector base of a debug field for this build's lane count
   function automatic int field_base(input int wide_lsb, input int narrow_lsb);
      if (LANES == sideband_pkg::WIDE_LANES) begin
         return wide_lsb;
      end else begin
         return narrow_lsb;
      end
   endfunction

   // bases fixed at build time, never moved by traffic
   localparam int CHK_LTS_LSB = field_base(sideband_pkg::LTS_WIDE_LSB,
      sideband_pkg::LTS_NARROW_LSB);   // training state source
   localparam int CHK_LANE_LSB = field_base(sideband_pkg::LANE_WIDE_LSB,
      sideband_pkg::LANE_NARROW_LSB);  // active lane source

   // a clean stepping cycle: enabled and out of reset
   sequence s_step;
      clk_en && !rst;
   endsequence

   // a frozen cycle: enable low and out of reset
   sequence s_frozen;
      !clk_en && !rst;
   endsequence

   property p_int_sts;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> int_sts_app == $past(int_sts_core);
   endproperty
   a_int_sts: assert property (p_int_sts) else $error("interrupt status not delayed"); // RQ1

   property p_busdev;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> busdev_app == $past(busdev_core);
   endproperty
   a_busdev: assert property (p_busdev) else $error("bus device copy wrong"); // RQ2

   property p_devcsr;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> devcsr_app == $past(devcsr_core);
   endproperty
   a_devcsr: assert property (p_devcsr) else $error("device csr copy wrong"); // RQ3

   property p_linkcsr;
      @(posedge sys_clk) disable iff (rst)
      s_step ##1 s_step |=> linkcsr_app == $past(linkcsr_core) &&
         $past(linkcsr_app) == $past(linkcsr_core, 2);
   endproperty
   a_linkcsr: assert property (p_linkcsr) else $error("link csr copy wrong"); // RQ4

   property p_tcvcmap;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> tcvcmap_app == $past(tcvcmap_core);
   endproperty
   a_tcvcmap: assert property (p_tcvcmap) else $error("channel map copy wrong"); // RQ5

   property p_cpl_err;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> cpl_err_app == $past(cpl_err_core);
   endproperty
   a_cpl_err: assert property (p_cpl_err) else $error("completion error copy wrong"); // RQ6

   property p_msi_num;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> msi_num_app == $past(msi_num_core);
   endproperty
   a_msi_num: assert property (p_msi_num) else $error("msi number copy wrong"); // RQ7

   property p_cpl_pending;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> cpl_pending_app == $past(cpl_pending_core);
   endproperty
   a_cpl_pending: assert property (p_cpl_pending) else $error("pending copy wrong"); // RQ8

   property p_lts;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> debug_app[sideband_pkg::DBG_LTS_LSB +: sideband_pkg::LTS_WIDTH] ==
         $past(test_core[CHK_LTS_LSB +: sideband_pkg::LTS_WIDTH], sideband_pkg::DELAY_CYCLES);
   endproperty
   a_lts: assert property (p_lts) else $error("training state field wrong"); // RQ10

   property p_lane;
      @(posedge sys_clk) disable iff (rst)
      s_step |=> debug_app[sideband_pkg::DBG_LANE_LSB +: sideband_pkg::LANE_WIDTH] ==
         $past(test_core[CHK_LANE_LSB +: sideband_pkg::LANE_WIDTH], sideband_pkg::DELAY_CYCLES);
   endproperty
   a_lane: assert property (p_lane) else $error("active lane field wrong"); // RQ11

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      s_frozen |=> $stable(debug_app) && $stable(linkcsr_app) && $stable(int_sts_app) &&
         $stable(busdev_app) && $stable(devcsr_app) && $stable(tcvcmap_app) &&
         $stable(cpl_err_app) && $stable(msi_num_app) && $stable(cpl_pending_app);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while disabled"); // RQ12

   // reset wins over a low enable and clears every output
   property p_reset_clear;
      @(posedge sys_clk)
      rst |=> !int_sts_app && !cpl_pending_app && busdev_app == '0 && devcsr_app == '0 &&
         linkcsr_app == '0 && tcvcmap_app == '0 && cpl_err_app == '0 &&
         msi_num_app == '0 && debug_app == '0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
endmodule

/* File: test/core_side_model.sv */
// far-side model: endpoint core driving its sideband outputs
`timescale 1ns/1ps
module core_side_model (
   input wire logic sys_clk,                                        // system clock
   input wire logic advance,                                        // step pattern each edge
   output logic int_sts_core,                                       // interrupt status
   output logic [sideband_pkg::BUSDEV_WIDTH-1:0] busdev_core,       // bus/device number
   output logic [sideband_pkg::DEVCSR_WIDTH-1:0] devcsr_core,       // device csr
   output logic [sideband_pkg::LINKCSR_WIDTH-1:0] linkcsr_core,     // link csr
   output logic [sideband_pkg::TCVCMAP_WIDTH-1:0] tcvcmap_core,     // tc/vc map
   output logic [sideband_pkg::CPLERR_WIDTH-1:0] cpl_err_core,      // completion error
   output logic [sideband_pkg::MSINUM_WIDTH-1:0] msi_num_core,      // msi number
   output logic cpl_pending_core,                                   // completion pending
   output logic [sideband_pkg::TEST_WIDTH-1:0] test_core            // test vector
);
   logic [31:0] step = 32'h0; // pattern index
   logic [31:0] seed;         // mixed pattern word
   // ------------------------------------------------------------
   // pattern source, new values every cycle so stale data shows
   // ------------------------------------------------------------
   assign seed = step * 32'h9E37_79B1;
   always @(posedge sys_clk) begin
      if (advance) begin
         step <= step + 32'h1;
      end
   end
   // each word of the test vector differs, so the two lane maps differ
   always_comb begin
      {int_sts_core, cpl_pending_core, cpl_err_core, msi_num_core} = seed[9:0];
      busdev_core = seed[31:19];
      devcsr_core = ~seed;
      linkcsr_core = seed ^ 32'h5A5A_5A5A;
      tcvcmap_core = seed[27:4];
      for (int i = 0; i < 16; i++) begin
         test_core[i*32 +: 32] = seed ^ (i * 32'h1111_1111);
      end
   end
endmodule

/* File: test/sideband_retiming_stage_tb_top.sv */
// self-checking bench for the sideband retiming stage
`timescale 1ns/1ps
module sideband_retiming_stage_tb_top;
   logic sys_clk = 1'b0; // system clock
   logic rst = 1'b1;     // synchronous reset
   logic clk_en = 1'b0;  // stage enable
   logic advance = 1'b1; // model pattern step
   int n_errors = 0;     // mismatches
   int cmp_count = 0;    // comparisons
   int cycles = 0;       // timeout counter
   logic int_sts_core, cpl_pending_core, int_sts_app, cpl_pending_app;
   logic [12:0] busdev_core, busdev_app;
   logic [31:0] devcsr_core, devcsr_app, linkcsr_core, linkcsr_app;
   logic [23:0] tcvcmap_core, tcvcmap_app;
   logic [2:0] cpl_err_core, cpl_err_app;
   logic [4:0] msi_num_core, msi_num_app;
   logic [511:0] test_core;
   logic [8:0] debug_app, debug_narrow; // wide and narrow lane maps
   logic [110:0] in_cat, out_cat;       // all plain sideband fields
   assign in_cat = {int_sts_core, busdev_core, devcsr_core, linkcsr_core, tcvcmap_core,
      cpl_err_core, msi_num_core, cpl_pending_core};
   assign out_cat = {int_sts_app, busdev_app, devcsr_app, linkcsr_app, tcvcmap_app,
      cpl_err_app, msi_num_app, cpl_pending_app};
   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   core_side_model i_core (.sys_clk, .advance, .int_sts_core, .busdev_core, .devcsr_core,
      .linkcsr_core, .tcvcmap_core, .cpl_err_core, .msi_num_core, .cpl_pending_core,
      .test_core);
   sideband_retiming_stage #(.LANES(8)) i_dut (.sys_clk, .rst, .clk_en, .int_sts_core,
      .busdev_core, .devcsr_core, .linkcsr_core, .tcvcmap_core, .cpl_err_core, .msi_num_core,
      .cpl_pending_core, .test_core, .int_sts_app, .busdev_app, .devcsr_app, .linkcsr_app,
      .tcvcmap_app, .cpl_err_app, .msi_num_app, .cpl_pending_app, .debug_app);
   sideband_retiming_stage #(.LANES(4)) i_dut_narrow (.sys_clk, .rst, .clk_en, .int_sts_core,
      .busdev_core, .devcsr_core, .linkcsr_core, .tcvcmap_core, .cpl_err_core, .msi_num_core,
      .cpl_pending_core, .test_core, .int_sts_app(), .busdev_app(), .devcsr_app(),
      .linkcsr_app(), .tcvcmap_app(), .cpl_err_app(), .msi_num_app(), .cpl_pending_app(),
      .debug_app(debug_narrow));
   // clock, 40 ns period
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // hang guard, far above the 46 cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 2000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [511:0] got, input logic [511:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: %s mismatch", $time, what);
      end
   endtask
   task automatic tally_and_finish();
      $display("errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // every enabled edge: outputs equal the inputs seen just before it
   task automatic stream_check(input int n);
      logic [110:0] snap;
      logic [511:0] t;
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         snap = in_cat;
         t = test_core;
         #1;
         check(out_cat, snap, "sideband copy");
         check(debug_app, {t[88 +: 4], t[0 +: 5]}, "wide debug");
         check(debug_narrow, {t[408 +: 4], t[320 +: 5]}, "narrow debug");
      end
   endtask
   // enable low freezes every output of the eight-lane stage while the core keeps changing
   task automatic hold_check();
      logic [110:0] held;
      logic [8:0] held_dbg;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      #1;
      held = out_cat;
      held_dbg = debug_app;
      repeat (3) begin
         @(posedge sys_clk);
         #1;
         check(out_cat, held, "hold sideband");
         check(debug_app, held_dbg, "hold debug");
      end
      @(posedge sys_clk);
      clk_en <= 1'b1;
   endtask
   // reset clears outputs and wins over a low enable
   task automatic reset_check(input int len);
      @(posedge sys_clk);
      rst <= 1'b1;
      clk_en <= 1'b0;
      repeat (len) begin
         @(posedge sys_clk);
         #1;
         check(out_cat, 111'h0, "reset sideband");
         check({debug_app, debug_narrow}, 18'h0, "reset debug");
      end
      @(posedge sys_clk);
      rst <= 1'b0;
      clk_en <= 1'b1;
   endtask
   // main sequence
   initial begin
      reset_check(5);
      stream_check(20);
      hold_check();
      stream_check(4);
      reset_check(2);
      stream_check(6);
      tally_and_finish();
   end
endmodule
